// File: rtc_control.sv
`timescale 1ns/1ps
module rtc_control
  import rtc_ctrl_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        counter_source_clock,
  input  wire logic        compare_match,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             divided_count_clock,
  output logic             counter_clear,
  output logic             counter_running,
  output rtc_ctrl_pkg::mode_t active_mode,
  output logic             hour_format_select
);
  import rtc_ctrl_pkg::*;

  // Control fields
  logic [3:0]  div_reg;           // Divider code
  mode_t       mode_reg;          // Operating mode
  logic        clear_on_match;    // Clear on compare/alarm 0
  logic        hour_reg;          // Hour format
  logic        en_reg;            // Enable as written
  logic        srst_reg;          // Soft reset in progress
  logic        sync_pending_flag; // Crossing busy
  logic        debug_run_control; // Survives soft reset
  logic        guard_reg;         // Write guard
  logic        req_reg;           // Handshake request
  // Bus state
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        aw_have;
  logic        w_have;
  // Counter-domain results
  logic        cnt_edge;
  logic        cnt_enabled;
  logic        cnt_srst;
  logic [DIV_CNT_W-1:0] pre_cnt;
  sync_if sif ();

  // Merge the written byte lanes into an old word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Current control word as software sees it
  function automatic logic [15:0] ctrl_view();
    logic [15:0] v;
    v = CTRL_RESET;
    v[SRST_BIT]          = srst_reg;
    v[EN_BIT]            = en_reg;
    v[MODE_LO +: 2]      = mode_reg;
    v[DIV_LO +: 4]       = div_reg;
    if (mode_reg != MODE_NARROW) begin
      v[MCLR_BIT] = clear_on_match;
    end
    if (mode_reg == MODE_CALENDAR) begin
      v[HOUR_BIT] = hour_reg;
    end
    return v;
  endfunction

  logic        wr_fire;
  logic        ctrl_wr;
  logic [31:0] ctrl_new;
  assign wr_fire  = aw_have && w_have && !s_axi_bvalid;
  assign ctrl_wr  = wr_fire && aw_addr == CTRL_OFFSET && !guard_reg;
  assign ctrl_new = merge({16'h0000, ctrl_view()}, w_data, w_strb);

  // Write address and data are taken independently
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      aw_have <= 1'b0;
      w_have  <= 1'b0;
      aw_addr <= 12'h000;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have <= 1'b1;
        aw_addr <= {s_axi_awaddr[11:2], 2'h0};
      end else if (wr_fire) begin
        aw_have <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_have <= 1'b0;
      end
    end
  end
  assign s_axi_awready = !aw_have && !s_axi_bvalid;
  assign s_axi_wready  = !w_have && !s_axi_bvalid;

  // Write response; unmapped addresses answer SLVERR
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= AXI_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (aw_addr > MATCH_OFFSET) ? AXI_SLVERR : AXI_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control fields; soft reset wins over every other field
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      div_reg        <= CTRL_RESET[DIV_LO +: 4];
      mode_reg       <= MODE_WIDE;
      clear_on_match <= 1'b0;
      hour_reg       <= 1'b0;
      en_reg         <= 1'b0;
      srst_reg       <= 1'b0;
    end else if (cnt_srst) begin
      // Crossing done: restore reset values, peripheral disabled
      div_reg        <= CTRL_RESET[DIV_LO +: 4];
      mode_reg       <= MODE_WIDE;
      clear_on_match <= 1'b0;
      hour_reg       <= 1'b0;
      en_reg         <= 1'b0;
      srst_reg       <= 1'b0;
    end else if (ctrl_wr && !srst_reg) begin
      if (ctrl_new[SRST_BIT]) begin
        srst_reg <= 1'b1;
      end else begin
        // Zero to soft reset is simply not acted on
        en_reg <= ctrl_new[EN_BIT];
        if (!en_reg) begin
          div_reg        <= ctrl_new[DIV_LO +: 4];
          mode_reg       <= mode_t'(ctrl_new[MODE_LO +: 2]);
          clear_on_match <= ctrl_new[MCLR_BIT];
          hour_reg       <= ctrl_new[HOUR_BIT];
        end
      end
    end
  end

  // Debug control and write guard live outside the soft reset
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      debug_run_control <= 1'b0;
      guard_reg         <= 1'b0;
    end else if (wr_fire) begin
      if (aw_addr == DBG_OFFSET && w_strb[0]) begin
        debug_run_control <= w_data[0];
      end
      if (aw_addr == GUARD_OFFSET && w_strb[0]) begin
        guard_reg <= w_data[0];
      end
    end
  end

  // Pending flag: set by an enable change or soft reset write
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sync_pending_flag <= 1'b0;
      req_reg           <= 1'b0;
    end else begin
      if (ctrl_wr && !srst_reg &&
          (ctrl_new[SRST_BIT] || ctrl_new[EN_BIT] != en_reg)) begin
        sync_pending_flag <= 1'b1;
        req_reg           <= 1'b1;
      end else if (req_reg && sif.ack) begin
        req_reg <= 1'b0;
      end else if (!req_reg && !sif.ack && sync_pending_flag) begin
        sync_pending_flag <= 1'b0;
      end
    end
  end
  assign sif.req  = req_reg;
  assign sif.en   = en_reg;
  assign sif.srst = srst_reg;

  rtc_sync_cdc u_cdc (
    .clk_sys     (clk_sys),
    .resetn      (resetn),
    .cnt_clk_pin (counter_source_clock),
    .sif         (sif),
    .cnt_edge    (cnt_edge),
    .cnt_enabled (cnt_enabled),
    .cnt_srst    (cnt_srst)
  );

  // Divider tap: true once every 2^code source edges
  function automatic logic div_tap(input logic [DIV_CNT_W-1:0] cnt,
                                   input logic [3:0]           code);
    logic [DIV_CNT_W:0] mask;
    mask = ({{DIV_CNT_W{1'b0}}, 1'b1} << code) - 1'b1;
    return (cnt & mask[DIV_CNT_W-1:0]) == mask[DIV_CNT_W-1:0];
  endfunction

  // Divider runs on source-clock edges, no synchroniser on the code
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pre_cnt             <= '0;
      divided_count_clock <= 1'b0;
    end else begin
      divided_count_clock <= 1'b0;
      if (cnt_edge && cnt_enabled) begin
        pre_cnt <= pre_cnt + 1'b1;
        if (div_reg == 4'h0 || div_reg > DIV_MAX_CODE) begin
          divided_count_clock <= 1'b1;
        end else begin
          divided_count_clock <= div_tap(pre_cnt, div_reg);
        end
      end
    end
  end

  // Outputs toward the counter core
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      counter_clear      <= 1'b0;
      counter_running    <= 1'b0;
      active_mode        <= MODE_WIDE;
      hour_format_select <= 1'b0;
    end else begin
      counter_clear <= cnt_srst | (compare_match && clear_on_match
                       && mode_reg != MODE_NARROW);
      counter_running    <= cnt_enabled;
      active_mode        <= mode_reg;
      hour_format_select <= hour_reg & (mode_reg == MODE_CALENDAR);
    end
  end

  // Read channel, one-cycle answer
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= AXI_OKAY;
      unique case ({s_axi_araddr[11:2], 2'h0})
        CTRL_OFFSET:   s_axi_rdata <= {16'h0000, ctrl_view()};
        STATUS_OFFSET: s_axi_rdata <= 32'(sync_pending_flag) << BUSY_BIT;
        DBG_OFFSET:    s_axi_rdata <= {31'h0, debug_run_control};
        GUARD_OFFSET:  s_axi_rdata <= {31'h0, guard_reg};
        MATCH_OFFSET:  s_axi_rdata <= {31'h0, counter_running};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= AXI_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  assign s_axi_arready = !s_axi_rvalid;

  // Checks
  property p_protect;
    @(posedge clk_sys) disable iff (!resetn)
      (en_reg && !cnt_srst) |=> $stable(div_reg) && $stable(mode_reg);
  endproperty
  a_protect: assert property (p_protect) else $error("protected write");
  property p_srst_busy;
    @(posedge clk_sys) disable iff (!resetn)
      srst_reg |-> sync_pending_flag;
  endproperty
  a_srst_busy: assert property (p_srst_busy) else $error("srst busy");
  property p_srst_off;
    @(posedge clk_sys) disable iff (!resetn)
      cnt_srst |=> !en_reg && !srst_reg && mode_reg == MODE_WIDE;
  endproperty
  a_srst_off: assert property (p_srst_off) else $error("srst state");
  property p_en_pend;
    @(posedge clk_sys) disable iff (!resetn)
      $changed(en_reg) && !cnt_srst |-> sync_pending_flag;
  endproperty
  a_en_pend: assert property (p_en_pend) else $error("enable pend");
  property p_narrow;
    @(posedge clk_sys) disable iff (!resetn)
      mode_reg == MODE_NARROW && !cnt_srst |=> !counter_clear;
  endproperty
  a_narrow: assert property (p_narrow) else $error("narrow clear");
  property p_match;
    @(posedge clk_sys) disable iff (!resetn)
      compare_match && clear_on_match && mode_reg == MODE_WIDE
        |=> counter_clear;
  endproperty
  a_match: assert property (p_match) else $error("match clear");
  property p_guard;
    @(posedge clk_sys) disable iff (!resetn)
      guard_reg && !srst_reg && !cnt_srst |=> $stable(en_reg);
  endproperty
  a_guard: assert property (p_guard) else $error("guard");
  property p_hour;
    @(posedge clk_sys) disable iff (!resetn)
      mode_reg != MODE_CALENDAR |=> !hour_format_select;
  endproperty
  a_hour: assert property (p_hour) else $error("hour view");
endmodule

// File: rtc_ctrl_pkg.sv
package rtc_ctrl_pkg;
  // Register map and field layout of the control word
  localparam logic [11:0] CTRL_OFFSET     = 12'h000;
  localparam logic [11:0] STATUS_OFFSET   = 12'h004;
  localparam logic [11:0] DBG_OFFSET      = 12'h008;
  localparam logic [11:0] GUARD_OFFSET    = 12'h00C;
  localparam logic [11:0] MATCH_OFFSET    = 12'h010;
  localparam int          SRST_BIT        = 0;
  localparam int          EN_BIT          = 1;
  localparam int          MODE_LO         = 2;
  localparam int          HOUR_BIT        = 6;
  localparam int          MCLR_BIT        = 7;
  localparam int          DIV_LO          = 8;
  localparam int          BUSY_BIT        = 7;
  localparam logic [15:0] CTRL_RESET      = 16'h0000;
  localparam logic [3:0]  DIV_MAX_CODE    = 4'hA;
  localparam logic [1:0]  AXI_OKAY        = 2'h0;
  localparam logic [1:0]  AXI_SLVERR      = 2'h2;
  localparam int          DIV_CNT_W       = 10;
  // Operating modes of the counter
  typedef enum logic [1:0] {
    MODE_WIDE     = 2'h0,
    MODE_NARROW   = 2'h1,
    MODE_CALENDAR = 2'h2,
    MODE_RESERVED = 2'h3
  } mode_t;
endpackage

// File: rtc_src_model.sv
`timescale 1ns/1ps
// Counter side of the block: slow source clock and match line
module rtc_src_model (
  input  wire logic match_req,
  output logic      counter_source_clock,
  output logic      compare_match
);
  // Source runs free, with a phase unrelated to the system clock
  initial begin
    counter_source_clock = 1'b0;
    #7;
    forever #85.3 counter_source_clock = ~counter_source_clock;
  end
  // Match level moves only on source edges, as the core would
  initial compare_match = 1'b0;
  always @(posedge counter_source_clock) compare_match <= match_req;
endmodule

// File: rtc_sync_cdc.sv
`timescale 1ns/1ps
// Counter-domain side of the enable / soft-reset handshake.
// The counter clock arrives as a sampled input, so the crossing is
// a 4-phase handshake on three-flop synchronisers.
module rtc_sync_cdc (
  input  wire logic clk_sys,
  input  wire logic resetn,
  input  wire logic cnt_clk_pin,
  sync_if.cnt_side  sif,
  output logic      cnt_edge,
  output logic      cnt_enabled,
  output logic      cnt_srst
);
  logic [2:0] clk_s;    // Source clock sampler
  logic [2:0] req_s;    // Request synchroniser
  logic       seen;     // Request taken in the counter domain
  logic       ack_reg;  // Acknowledge returned after the counter edge

  // Sample the source clock; a rising edge counts when clk_s[1] is high and clk_s[2] still low
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      clk_s <= 3'h0;
    end else begin
      clk_s <= {clk_s[1:0], cnt_clk_pin};
    end
  end
  assign cnt_edge = clk_s[1] & ~clk_s[2];

  // Request level passes three flops before use
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      req_s <= 3'h0;
    end else begin
      req_s <= {req_s[1:0], sif.req};
    end
  end

  // The change lands on a counter edge, then acknowledges
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      seen        <= 1'b0;
      ack_reg     <= 1'b0;
      cnt_enabled <= 1'b0;
      cnt_srst    <= 1'b0;
    end else begin
      cnt_srst <= 1'b0;
      if (req_s[1] && req_s[2] && !seen && cnt_edge) begin
        seen        <= 1'b1;
        ack_reg     <= 1'b1;
        cnt_enabled <= sif.en & ~sif.srst;
        cnt_srst    <= sif.srst;
      end else if (!req_s[1] && !req_s[2]) begin
        seen    <= 1'b0;
        ack_reg <= 1'b0;
      end
    end
  end
  assign sif.ack = ack_reg;
endmodule

// File: sync_if.sv
`timescale 1ns/1ps
// Handshake between the bus side and the counter-domain crossing
interface sync_if;
  logic req;   // Toggle-free request level toward the counter domain
  logic ack;   // Synchronised acknowledge back to the bus side
  logic en;    // Enable level carried with the request
  logic srst;  // Soft reset carried with the request
  modport bus_side (output req, output en, output srst, input ack);
  modport cnt_side (input req, input en, input srst, output ack);
endinterface

// File: tb.sv
`timescale 1ns/1ps
module tb;
  import rtc_ctrl_pkg::*;
  logic        clk_sys;   // System clock
  logic        resetn;    // Active-low reset
  logic        match_req; // Asks the model for a match
  logic [11:0] awaddr;
  logic        awvalid;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        bready;
  logic [11:0] araddr;
  logic        arvalid;
  logic        rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        tick, clr, running, hour, src_clk, match;
  mode_t       mode;
  logic [31:0] rd;        // Last read data
  logic [1:0]  rs;        // Last read response
  int          bad_count;
  int          checked;
  int          cycles;    // Watchdog count
  int          ticks;     // Divided tick pulses seen
  int          clears;    // Counter clear pulses seen
  int          c0;
  rtc_control i_dut (.clk_sys(clk_sys), .resetn(resetn),
    .counter_source_clock(src_clk), .compare_match(match),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .divided_count_clock(tick), .counter_clear(clr),
    .counter_running(running), .active_mode(mode),
    .hour_format_select(hour));
  rtc_src_model i_src (.match_req(match_req),
    .counter_source_clock(src_clk), .compare_match(match));
  // System clock, 100 MHz
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Pulse counters and watchdog
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (tick === 1'b1) ticks <= ticks + 1;
    if (clr === 1'b1) clears <= clears + 1;
    if (cycles == 60000) begin
      bad_count = bad_count + 1;
      summarize();
    end
  end
  // Verdict and end of run
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    checked = checked + 1;
    if (g !== e) begin
      bad_count = bad_count + 1;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  // Write: address and data offered together, each dropped when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    bit ad, wd;
    ad = 0;
    wd = 0;
    @(posedge clk_sys);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wstrb   <= s;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge clk_sys);
      if (!ad && awready === 1'b1) begin
        ad = 1;
        awvalid <= 1'b0;
      end
      if (!wd && wready === 1'b1) begin
        wd = 1;
        wvalid <= 1'b0;
      end
    end
    // Response must follow both items
    while (bvalid !== 1'b1) @(posedge clk_sys);
    bready <= 1'b0;
    chk("bresp", AXI_OKAY, {30'h0, bresp});
  endtask
  task automatic rdr(input logic [11:0] a);
    @(posedge clk_sys);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge clk_sys); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge clk_sys);
    rready <= 1'b0;
    rd = rdata;
    rs = rresp;
  endtask
  // Read a register and compare it with the expected word
  task automatic rc(input string what, input logic [11:0] a,
                    input logic [31:0] e);
    rdr(a);
    chk(what, e, rd);
  endtask
  // Poll the pending flag until the crossing is done
  task automatic wait_sync();
    do rdr(STATUS_OFFSET); while (rd[BUSY_BIT] !== 1'b0);
  endtask
  // Raise a match and count the clear pulses it causes
  task automatic do_match(output int n);
    c0 = clears;
    @(posedge clk_sys);
    match_req <= 1'b1;
    repeat (40) @(posedge clk_sys);
    match_req <= 1'b0;
    repeat (40) @(posedge clk_sys);
    n = clears - c0;
  endtask
  int n;
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready, match_req} = '0;
    {bad_count, checked, cycles, ticks, clears} = '0;
    resetn = 1'b0;
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    rc("ctrl reset", CTRL_OFFSET, {16'h0, CTRL_RESET});
    rc("status reset", STATUS_OFFSET, 32'h0000_0000);
    rdr(12'h020);
    chk("unmapped resp", AXI_SLVERR, {30'h0, rs});
    chk("unmapped data", 32'h0000_0000, rd);
    // Calendar view, 32-bit write, every field shown
    wr(CTRL_OFFSET, 32'h0000_03C8, 4'hF);
    rc("ctrl cal", CTRL_OFFSET, 32'h0000_03C8);
    rc("no pending", STATUS_OFFSET, 32'h0000_0000);
    chk("mode out", MODE_CALENDAR, {30'h0, mode});
    chk("hour out", 32'h1, {31'h0, hour});
    // Single byte lanes
    wr(CTRL_OFFSET, 32'h0000_0500, 4'h2);
    rc("byte1", CTRL_OFFSET, 32'h0000_05C8);
    wr(CTRL_OFFSET, 32'h0000_0088, 4'h1);
    rc("byte0", CTRL_OFFSET, 32'h0000_0588);
    chk("hour 24h", 32'h0, {31'h0, hour});
    // Narrow view hides clear-on-match and hour bits
    wr(CTRL_OFFSET, 32'h0000_0284, 4'h3);
    rc("narrow", CTRL_OFFSET, 32'h0000_0204);
    chk("mode narrow", MODE_NARROW, {30'h0, mode});
    // Enable reads back at once, pending until crossed
    wr(CTRL_OFFSET, 32'h0000_0286, 4'h3);
    rc("en readback", CTRL_OFFSET, 32'h0000_0206);
    rc("pending set", STATUS_OFFSET, 32'h0000_0080);
    wait_sync();
    chk("running", 32'h1, {31'h0, running});
    // Divide by 4: 16 ticks in 64 source periods, give or take one
    c0 = ticks;
    repeat (64) @(posedge src_clk);
    n = ticks - c0;
    chk("div4 ticks", 32'h1, {31'h0, n >= 15 && n <= 17});
    do_match(n);
    chk("narrow no clear", 32'h0, n);
    // Protected fields hold while enabled
    wr(CTRL_OFFSET, 32'h0000_0A82, 4'h3);
    rc("protected", CTRL_OFFSET, 32'h0000_0206);
    wr(CTRL_OFFSET, 32'h0000_0284, 4'h3);
    wait_sync();
    chk("stopped", 32'h0, {31'h0, running});
    // Wide mode with clear-on-match
    wr(CTRL_OFFSET, 32'h0000_0080, 4'h3);
    repeat (2) @(posedge clk_sys);
    chk("mode wide", MODE_WIDE, {30'h0, mode});
    wr(CTRL_OFFSET, 32'h0000_0082, 4'h3);
    wait_sync();
    do_match(n);
    chk("wide clear", 32'h1, {31'h0, n > 0});
    // Zero on the soft reset bit changes nothing
    wr(CTRL_OFFSET, 32'h0000_0082, 4'h1);
    rc("srst zero", CTRL_OFFSET, 32'h0000_0082);
    rc("srst zero st", STATUS_OFFSET, 32'h0000_0000);
    // Soft reset discards the rest of its write
    wr(DBG_OFFSET, 32'h0000_0001, 4'hF);
    wr(CTRL_OFFSET, 32'h0000_0A4F, 4'h3);
    rc("srst busy", CTRL_OFFSET, 32'h0000_0083);
    rc("srst pend", STATUS_OFFSET, 32'h0000_0080);
    wait_sync();
    rc("srst done", CTRL_OFFSET, 32'h0000_0000);
    chk("srst stop", 32'h0, {31'h0, running});
    rc("debug kept", DBG_OFFSET, 32'h0000_0001);
    // Write guard blocks the control word
    wr(GUARD_OFFSET, 32'h0000_0001, 4'hF);
    wr(CTRL_OFFSET, 32'h0000_0300, 4'hF);
    rc("guarded", CTRL_OFFSET, 32'h0000_0000);
    wr(GUARD_OFFSET, 32'h0000_0000, 4'hF);
    wr(CTRL_OFFSET, 32'h0000_0300, 4'h2);
    rc("unguarded", CTRL_OFFSET, 32'h0000_0300);
    summarize();
  end
endmodule
